// ### design/rbm_fifo.sv
`timescale 1ns/1ps
module rbm_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Fill side
    input wire logic push,
    input wire logic [W-1:0] din,
    output logic full,
    // Drain side
    input wire logic pop,
    output logic [W-1:0] dout,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;

    // Storage carries no reset, only the pointers and the count do
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_r] <= din;
        end
    end

    // Caller never pushes when full nor pops when empty
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    assign dout = mem[rp_r];
    assign full = (cnt_r == (AW+1)'(DEPTH));
    assign count = cnt_r;
endmodule

// ### design/rbm_rx_dma.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
// Operation
// - Idle, enabled, done flag clear: burst-read descriptor at pointer, configured length.
// - Idle, enabled, done flag set: read only the link field, then advance.
// - Descriptor read done: owned by us go wait for data, else idle and halted flag.
// - Drain go when a whole packet is queued or current bytes exceed drain level.
// - On drain go write min(current bytes, buffer left) at write pointer; shrink left.
// - Buffer empty with bytes pending: write status with holder and continues set.
// - Packet finished: write final status, holder set, continues clear, errors and length.
// - Data write done returns to waiting; status write done goes to advance.
// - Advance with link: load pointer from link, clear done flag, read descriptor.
// - Advance with null link: set done flag, set halted flag, go idle.
// - Any load of the descriptor pointer clears the done flag.
// - Descriptor pointer is a 32-bit register with the current descriptor address.
// - Queued packets count up on MAC packet end, down when a packet is finished.
// - Current packet bytes count only bytes held, never above store capacity.
// - Whole descriptor read in one burst unless the burst limit is under 12 bytes (code then reads just 8 bytes); one buffer pointer and count cached.
// - Status in every descriptor filled, final status in the last; length field holds bytes actually written.
// - Out of descriptors, data keeps buffering; store overflow raises overrun flag.
module rbm_rx_dma
    import rbm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // MAC fill side
    input wire logic mac_valid,
    input wire rbm_macw_t mac_word,
    // Host bus master port
    output logic bm_req_valid,
    output rbm_req_t bm_req,
    output logic bm_wvalid,
    output logic [31:0] bm_wdata,
    input wire logic bm_rvalid,
    input wire logic [31:0] bm_rdata,
    input wire logic bm_done
);

    // ****************************************
    // State
    // ****************************************
    rbm_state_t st_r;
    logic rxe_r;
    logic recv_descriptor_done_flag_r;
    logic halt_r;
    logic ovr_r;
    logic [31:0] recv_descriptor_pointer_r;
    logic [31:0] cfg_r;
    logic [31:0] link_r;
    logic [31:0] cmdsts_r;
    logic [31:0] bufptr_r;
    logic [SIZE_W-1:0] buf_left_r;
    logic [1:0] beat_r;
    logic [10:0] wbeats_r;
    logic [15:0] pkt_drained_r;
    logic [15:0] mac_len_r;
    logic [11:0] fifo_bytes_r;
    logic req_v_r;
    rbm_req_t req_r;
    logic wv_r;
    logic [31:0] wd_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // ****************************************
    // Receive store and packet records
    // ****************************************
    logic d_push;
    logic d_pop;
    logic d_full;
    logic [35:0] d_dout;
    logic [9:0] d_cnt;
    logic r_push;
    logic r_pop;
    logic r_full;
    logic [27:0] r_dout;
    logic [5:0] pkt_cnt;
    logic [2:0] pop_nb;

    // A word is taken only if both the data and the record store have room
    assign d_push = ce && mac_valid && !d_full && !r_full;
    assign r_push = d_push && mac_word.last;
    assign d_pop = ce && (st_r == ST_FRAG) && (wbeats_r != 11'h000);
    assign pop_nb = d_dout[35:33];

    rbm_fifo #(.W(36), .DEPTH(FIFO_DEPTH)) u_data (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(d_push),
        .din({mac_word.nbytes, mac_word.last, mac_word.data}),
        .full(d_full),
        .pop(d_pop),
        .dout(d_dout),
        .count(d_cnt)
    );

    // Count of records is the queued packet count
    rbm_fifo #(.W(28), .DEPTH(REC_DEPTH)) u_rec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .push(r_push),
        .din({mac_word.status, mac_len_r + {13'h0000, mac_word.nbytes}}),
        .full(r_full),
        .pop(r_pop),
        .dout(r_dout),
        .count(pkt_cnt)
    );

    // ****************************************
    // Decisions
    // ****************************************
    logic [15:0] cur_bytes;
    logic [15:0] buf_left16;
    logic [15:0] xfer_len;
    logic [15:0] burst_bytes;
    logic [15:0] desc_len;
    logic [SIZE_W-1:0] wr_size;
    logic [MAX_BURST_FIELD_W-1:0] max_burst_field;
    logic drain_go;
    logic eop;
    logic more_wb;
    logic own_halt;
    logic adv_load;
    logic adv_null;

    // Once a whole packet is queued its own length bounds the count
    assign cur_bytes = (pkt_cnt != 6'h00) ? r_dout[15:0] - pkt_drained_r
                                          : {4'h0, fifo_bytes_r};
    assign drain_go = (pkt_cnt != 6'h00) ||
        (cur_bytes > {5'h00, cfg_r[CFG_DRAIN_LSB +: DRAIN_W]});
    assign eop = (pkt_cnt != 6'h00) && (cur_bytes == 16'h0000);
    assign more_wb = (buf_left_r == '0) && (cur_bytes != 16'h0000);
    assign buf_left16 = {4'h0, buf_left_r};
    assign xfer_len = (cur_bytes < buf_left16) ? cur_bytes : buf_left16;
    assign max_burst_field = cfg_r[CFG_MAX_BURST_FIELD_LSB +: MAX_BURST_FIELD_W];
    assign burst_bytes = (max_burst_field == '0) ? BURST_MAX : 16'(WORD_BYTES << max_burst_field);
    // Whole descriptor in one burst; a smaller burst limit cuts the read to that limit
    assign desc_len = (burst_bytes < DESC_BYTES) ? burst_bytes : DESC_BYTES;
    assign wr_size = cmdsts_r[SIZE_W-1:0] - buf_left_r;
    assign r_pop = ce && (st_r == ST_BLOCK) && eop;
    assign own_halt = (st_r == ST_DREAD) && bm_done && cmdsts_r[CS_OWN];
    assign adv_load = (st_r == ST_ADV) && (link_r != LINK_NULL);
    assign adv_null = (st_r == ST_ADV) && (link_r == LINK_NULL);

    // ****************************************
    // Receive state machine
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            req_v_r <= 1'b0;
            req_r <= '0;
            wv_r <= 1'b0;
            wd_r <= 32'h0000_0000;
            link_r <= 32'h0000_0000;
            cmdsts_r <= 32'h0000_0000;
            bufptr_r <= 32'h0000_0000;
            buf_left_r <= '0;
            beat_r <= 2'h0;
            wbeats_r <= 11'h000;
        end else if (ce) begin
            req_v_r <= 1'b0;
            wv_r <= 1'b0;
            // Descriptor words arrive link, cmdsts, buffer pointer
            if (bm_rvalid && (st_r == ST_DREAD || st_r == ST_DREFR)) begin
                beat_r <= beat_r + 2'h1;
                unique case (beat_r)
                    2'h0: link_r <= bm_rdata;
                    2'h1: cmdsts_r <= bm_rdata;
                    2'h2: bufptr_r <= bm_rdata;
                    default: ;
                endcase
            end
            unique case (st_r)
                ST_IDLE: begin
                    if (rxe_r) begin
                        req_v_r <= 1'b1;
                        beat_r <= 2'h0;
                        if (!recv_descriptor_done_flag_r) begin
                            req_r <= '{1'b0, recv_descriptor_pointer_r + DESC_LINK, desc_len};
                            st_r <= ST_DREAD;
                        end else begin
                            req_r <= '{1'b0, recv_descriptor_pointer_r + DESC_LINK, WORD_BYTES};
                            st_r <= ST_DREFR;
                        end
                    end
                end
                ST_DREFR: begin
                    if (bm_done) begin
                        st_r <= ST_ADV;
                    end
                end
                ST_DREAD: begin
                    // Holder flag set means the driver still owns it
                    if (bm_done) begin
                        if (cmdsts_r[CS_OWN]) begin
                            st_r <= ST_IDLE;
                        end else begin
                            buf_left_r <= cmdsts_r[SIZE_W-1:0];
                            st_r <= ST_BLOCK;
                        end
                    end
                end
                ST_BLOCK: begin
                    // End of packet first so no status write is skipped
                    if (eop) begin
                        req_v_r <= 1'b1;
                        req_r <= '{1'b1, recv_descriptor_pointer_r + DESC_CMDSTS, WORD_BYTES};
                        wv_r <= 1'b1;
                        wd_r <= {2'b10, 2'b00, r_dout[27:16], 4'h0, wr_size};
                        st_r <= ST_DWRITE;
                    end else if (more_wb) begin
                        req_v_r <= 1'b1;
                        req_r <= '{1'b1, recv_descriptor_pointer_r + DESC_CMDSTS, WORD_BYTES};
                        wv_r <= 1'b1;
                        wd_r <= {2'b11, 14'h0000, 4'h0, wr_size};
                        st_r <= ST_DWRITE;
                    end else if (drain_go && cur_bytes != 16'h0000) begin
                        req_v_r <= 1'b1;
                        req_r <= '{1'b1, bufptr_r, xfer_len};
                        buf_left_r <= buf_left_r - xfer_len[SIZE_W-1:0];
                        bufptr_r <= bufptr_r + {16'h0000, xfer_len};
                        wbeats_r <= 11'((xfer_len + 16'h0003) >> 2);
                        st_r <= ST_FRAG;
                    end
                end
                ST_FRAG: begin
                    // One word per cycle; the host never stalls beats
                    if (wbeats_r != 11'h000) begin
                        wv_r <= 1'b1;
                        wd_r <= d_dout[31:0];
                        wbeats_r <= wbeats_r - 11'h001;
                    end
                    if (bm_done) begin
                        st_r <= ST_BLOCK;
                    end
                end
                ST_DWRITE: begin
                    if (bm_done) begin
                        st_r <= ST_ADV;
                    end
                end
                ST_ADV: begin
                    if (link_r != LINK_NULL) begin
                        req_v_r <= 1'b1;
                        req_r <= '{1'b0, link_r + DESC_LINK, desc_len};
                        beat_r <= 2'h0;
                        st_r <= ST_DREAD;
                    end else begin
                        st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Byte accounting of the receive store
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fifo_bytes_r <= 12'h000;
            pkt_drained_r <= 16'h0000;
            mac_len_r <= 16'h0000;
        end else if (ce) begin
            fifo_bytes_r <= fifo_bytes_r + (d_push ? {9'h000, mac_word.nbytes} : 12'h000)
                            - (d_pop ? {9'h000, pop_nb} : 12'h000);
            if (r_pop) begin
                pkt_drained_r <= 16'h0000;
            end else if (d_pop) begin
                pkt_drained_r <= pkt_drained_r + {13'h0000, pop_nb};
            end
            if (d_push) begin
                mac_len_r <= mac_word.last ? 16'h0000 : mac_len_r + {13'h0000, mac_word.nbytes};
            end
        end
    end

    // ****************************************
    // APB registers
    // ****************************************
    logic apb_wr;
    logic apb_setup;
    assign apb_wr = ce && psel && penable && pready_r && pwrite;
    assign apb_setup = ce && psel && !penable;

    // Pointer, done flag, enable and configuration
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            recv_descriptor_pointer_r <= RECV_DESCRIPTOR_POINTER_RST;
            recv_descriptor_done_flag_r <= 1'b0;
            rxe_r <= 1'b0;
            cfg_r <= CFG_RST;
        end else if (ce) begin
            if (apb_wr && paddr == A_CMD) begin
                rxe_r <= pwdata[CMD_RXE];
            end
            if (apb_wr && paddr == A_CFG) begin
                cfg_r <= pwdata;
            end
            // A driver write beats the engine's own load in the same cycle
            if (apb_wr && paddr == A_RECV_DESCRIPTOR_POINTER) begin
                recv_descriptor_pointer_r <= pwdata;
                recv_descriptor_done_flag_r <= 1'b0;
            end else if (adv_load) begin
                recv_descriptor_pointer_r <= link_r;
                recv_descriptor_done_flag_r <= 1'b0;
            end else if (adv_null) begin
                recv_descriptor_done_flag_r <= 1'b1;
            end
        end
    end

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            halt_r <= 1'b0;
            ovr_r <= 1'b0;
        end else if (ce) begin
            halt_r <= own_halt || adv_null ||
                (halt_r && !(apb_wr && paddr == A_ISR && pwdata[ISR_HALT]));
            ovr_r <= (mac_valid && (d_full || r_full)) ||
                (ovr_r && !(apb_wr && paddr == A_ISR && pwdata[ISR_OVR]));
        end
    end

    // Read data and error are settled in the setup cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            pready_r <= ce;
            if (apb_setup) begin
                pslverr_r <= 1'b0;
                unique case (paddr)
                    A_CMD: prdata_r <= {31'h0000_0000, rxe_r};
                    A_RECV_DESCRIPTOR_POINTER: prdata_r <= recv_descriptor_pointer_r;
                    A_CFG: prdata_r <= cfg_r;
                    A_ISR: prdata_r <= {30'h0000_0000, ovr_r, halt_r};
                    A_STAT: prdata_r <= {18'h0_0000, pkt_cnt, 4'h0, recv_descriptor_done_flag_r, st_r};
                    default: begin
                        prdata_r <= 32'h0000_0000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bm_req_valid = req_v_r;
    assign bm_req = req_r;
    assign bm_wvalid = wv_r;
    assign bm_wdata = wd_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_desc_wr_done;
        ce && st_r == ST_DWRITE && bm_done;
    endsequence
    sequence s_advance_read;
        st_r == ST_ADV ##1 st_r == ST_DREAD && bm_req_valid && !bm_req.write;
    endsequence

    a_idle_desc_read: assert property (ce && st_r == ST_IDLE && rxe_r && !recv_descriptor_done_flag_r |=>
        st_r == ST_DREAD && bm_req_valid && bm_req.addr == $past(recv_descriptor_pointer_r) && !bm_req.write)
        else $error("Descriptor read not started from idle");
    a_idle_refresh: assert property (ce && st_r == ST_IDLE && rxe_r && recv_descriptor_done_flag_r |=>
        st_r == ST_DREFR && bm_req_valid && bm_req.len == WORD_BYTES)
        else $error("Link refresh not started");
    a_owned_halts: assert property (ce && own_halt |=> st_r == ST_IDLE && halt_r)
        else $error("Owned descriptor did not halt");
    a_frag_length: assert property (ce && st_r == ST_BLOCK && !eop && !more_wb && drain_go
        && cur_bytes != 16'h0000 |=> bm_req.len == $past(xfer_len) && bm_req.write
        && buf_left_r == $past(buf_left_r) - $past(xfer_len[SIZE_W-1:0]))
        else $error("Data burst length wrong");
    a_more_status: assert property (ce && st_r == ST_BLOCK && !eop && more_wb |=>
        bm_wvalid && bm_wdata[CS_OWN] && bm_wdata[CS_MORE])
        else $error("Continuation status wrong");
    a_final_status: assert property (ce && st_r == ST_BLOCK && eop |=> bm_wvalid
        && bm_wdata[CS_OWN] && !bm_wdata[CS_MORE] && bm_wdata[SIZE_W-1:0] == $past(wr_size))
        else $error("Final status wrong");
    a_frag_return: assert property (ce && st_r == ST_FRAG && bm_done |=> st_r == ST_BLOCK)
        else $error("Data write did not return to wait");
    a_status_adv: assert property (s_desc_wr_done |=> s_advance_read or
        (st_r == ST_ADV ##1 st_r == ST_IDLE))
        else $error("Status write did not advance");
    a_link_load: assert property (ce && adv_load && !apb_wr |=> recv_descriptor_pointer_r == $past(link_r)
        && !recv_descriptor_done_flag_r) else $error("Link not loaded");
    a_null_link: assert property (ce && adv_null |=> st_r == ST_IDLE && recv_descriptor_done_flag_r && halt_r)
        else $error("Null link not handled");
    a_cur_bound: assert property (cur_bytes <= 16'(FIFO_BYTES))
        else $error("Current bytes above capacity");
    a_overrun: assert property (ce && mac_valid && d_full |=> ovr_r)
        else $error("Overflow not flagged");
endmodule

// ### shared/rbm_pkg.sv
package rbm_pkg;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_RECV_DESCRIPTOR_POINTER = 8'h04;
    localparam logic [7:0] A_CFG = 8'h08;
    localparam logic [7:0] A_ISR = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam int CMD_RXE = 0;
    localparam int ISR_HALT = 0;
    localparam int ISR_OVR = 1;
    localparam int CFG_DRAIN_LSB = 0;
    localparam int DRAIN_W = 11;
    localparam int CFG_MAX_BURST_FIELD_LSB = 20;
    localparam int MAX_BURST_FIELD_W = 3;
    localparam logic [31:0] CFG_RST = 32'h0000_0040;
    localparam logic [31:0] RECV_DESCRIPTOR_POINTER_RST = 32'h0000_0000;

    // ****************************************
    // Descriptor layout
    // ****************************************
    localparam int CS_OWN = 31;
    localparam int CS_MORE = 30;
    localparam int STS_W = 12;
    localparam int SIZE_W = 12;
    localparam logic [31:0] DESC_LINK = 32'h0000_0000;
    localparam logic [31:0] DESC_CMDSTS = 32'h0000_0004;
    localparam logic [31:0] DESC_BUFPTR = 32'h0000_0008;
    localparam logic [31:0] LINK_NULL = 32'h0000_0000;
    localparam logic [15:0] DESC_BYTES = 16'h000C;
    localparam logic [15:0] WORD_BYTES = 16'h0004;
    localparam logic [15:0] BURST_MAX = 16'h0200;

    // ****************************************
    // Receive store sizes
    // ****************************************
    localparam int FIFO_DEPTH = 512;
    localparam int FIFO_BYTES = 2048;
    localparam int REC_DEPTH = 32;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DREFR, ST_DREAD, ST_BLOCK, ST_FRAG, ST_DWRITE, ST_ADV
    } rbm_state_t;

    // Request to the host bus master
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [15:0] len;
    } rbm_req_t;

    // One word from the MAC fill side
    typedef struct packed {
        logic [31:0] data;
        logic [2:0] nbytes;
        logic last;
        logic [STS_W-1:0] status;
    } rbm_macw_t;

endpackage

// ### test/rbm_host_model.sv
`timescale 1ns/1ps
module rbm_host_model
    import rbm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Requests from the engine
    input wire logic bm_req_valid,
    input wire rbm_req_t bm_req,
    input wire logic bm_wvalid,
    input wire logic [31:0] bm_wdata,
    // Answers to the engine
    output logic bm_rvalid,
    output logic [31:0] bm_rdata,
    output logic bm_done
);
    // ****************************
    // Host memory, 8 KB of words
    // ****************************
    logic [31:0] mem [0:2047];
    rbm_req_t r;
    int n;
    int i;
    bit slow;
    // One request at a time; the answer alternates between prompt and slow
    initial begin
        bm_rvalid = 1'b0;
        bm_rdata = 32'h0000_0000;
        bm_done = 1'b0;
        slow = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (rst_n && bm_req_valid) begin
                r = bm_req;
                n = (int'(r.len) + 3) / 4;
                i = 0;
                while (i < n) begin
                    if (r.write && bm_wvalid) begin
                        mem[r.addr[12:2] + 11'(i)] = bm_wdata;
                        i++;
                    end else if (!r.write) begin
                        bm_rvalid <= 1'b1;
                        bm_rdata <= mem[r.addr[12:2] + 11'(i)];
                        i++;
                    end
                    @(posedge clk_sys);
                end
                // Released data lines must not keep the last beat
                bm_rvalid <= 1'b0;
                bm_rdata <= ~bm_rdata;
                repeat (slow ? 3 : 1) @(posedge clk_sys);
                bm_done <= 1'b1;
                @(posedge clk_sys);
                bm_done <= 1'b0;
                slow = !slow;
            end
        end
    end
endmodule

// ### test/tb_rx_descriptor_dma_manager.sv
`timescale 1ns/1ps
module tb_rx_descriptor_dma_manager
    import rbm_pkg::*;
;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, mac_valid, err;
    logic bm_req_valid, bm_wvalid, bm_rvalid, bm_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, bm_wdata, bm_rdata;
    rbm_macw_t mac_word;
    rbm_req_t bm_req;
    int miscompares = 0;
    int checks_done = 0;
    // Clock enable held high: freezing is not exercised
    rbm_rx_dma i_dut (.clk_sys, .rst_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mac_valid, .mac_word, .bm_req_valid, .bm_req,
        .bm_wvalid, .bm_wdata, .bm_rvalid, .bm_rdata, .bm_done);
    rbm_host_model i_host (.clk_sys, .rst_n, .bm_req_valid, .bm_req, .bm_wvalid, .bm_wdata,
        .bm_rvalid, .bm_rdata, .bm_done);
    // ****************************
    // Shared tasks
    // ****************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; an idle cycle follows so strobes never toggle twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic mac_send(input int n, input logic [31:0] base, input logic lst);
        for (int i = 0; i < n; i++) begin
            mac_valid <= 1'b1;
            mac_word <= '{data: base + 32'(i), nbytes: 3'd4, last: lst && (i == n - 1),
                status: 12'h0A5};
            @(posedge clk_sys);
        end
        mac_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Polls the status flags under a bounded count
    task automatic wait_isr(input int b);
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, A_ISR, 32'h0000_0000);
            if (q[b] === 1'b1) break;
        end
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_regs();
        apb(1'b0, A_CFG, 32'h0000_0000);
        chk(q, CFG_RST);
        apb(1'b0, A_RECV_DESCRIPTOR_POINTER, 32'h0000_0000);
        chk(q, RECV_DESCRIPTOR_POINTER_RST);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({q[30:0], err}, 32'h0000_0001);
    endtask
    // A 40-byte packet spills from one 32-byte buffer into the next
    task automatic t_chain();
        i_host.mem[64] = 32'h0000_0200;
        i_host.mem[65] = 32'h0000_0020;
        i_host.mem[66] = 32'h0000_1000;
        i_host.mem[128] = 32'h0000_0000;
        i_host.mem[129] = 32'h0000_0020;
        i_host.mem[130] = 32'h0000_1800;
        apb(1'b1, A_RECV_DESCRIPTOR_POINTER, 32'h0000_0100);
        apb(1'b1, A_CMD, 32'h0000_0001);
        mac_send(10, 32'hA000_0000, 1'b1);
        wait_isr(ISR_HALT);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        for (int i = 0; i < 8; i++) chk(i_host.mem[1024 + i], 32'hA000_0000 + 32'(i));
        for (int i = 0; i < 2; i++) chk(i_host.mem[1536 + i], 32'hA000_0008 + 32'(i));
        chk(i_host.mem[65] & 32'hC000_0000, 32'hC000_0000);
        chk(i_host.mem[129] & 32'hCFFF_0FFF, 32'h80A5_0008);
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk(q & 32'h0000_3F08, 32'h0000_0008);
    endtask
    // A descriptor still held by the driver halts the engine without writing
    task automatic t_owned();
        apb(1'b1, A_CMD, 32'h0000_0000);
        repeat (20) @(posedge clk_sys);
        i_host.mem[193] = 32'h8000_0020;
        apb(1'b1, A_ISR, 32'h0000_0003);
        apb(1'b1, A_RECV_DESCRIPTOR_POINTER, 32'h0000_0300);
        apb(1'b0, A_STAT, 32'h0000_0000);
        chk(q & 32'h0000_0008, 32'h0000_0000);
        apb(1'b1, A_CMD, 32'h0000_0001);
        wait_isr(ISR_HALT);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        chk(i_host.mem[193], 32'h8000_0020);
        apb(1'b1, A_CMD, 32'h0000_0000);
    endtask
    // With reception off the store fills up and then overflows
    task automatic t_overrun();
        repeat (20) @(posedge clk_sys);
        apb(1'b1, A_ISR, 32'h0000_0003);
        mac_send(520, 32'h0000_0000, 1'b0);
        apb(1'b0, A_ISR, 32'h0000_0000);
        chk(q & 32'h0000_0002, 32'h0000_0002);
    endtask
    // ****************************
    // Clock, sequence, watchdog
    // ****************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, mac_valid} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        mac_word = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_regs();
        t_chain();
        t_owned();
        t_overrun();
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        miscompares++;
        give_verdict();
    end
endmodule
